// ### include/fvp_pkg.sv
// constants, types and parameter contents for the vendor parameter block
// assumes a 100 MHz single clock and an AXI4-Lite register bus
package fvp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00; // status and sticky flags
  localparam logic [7:0] OFF_CMD = 8'h04; // command launch
  localparam logic [7:0] OFF_RESULT = 8'h08; // parameter byte result
  localparam logic [7:0] OFF_SUPPLY = 8'h60; // supply limits word
  localparam logic [7:0] OFF_FEAT = 8'h64; // feature and opcode word
  localparam logic [7:0] OFF_LOCK = 8'h68; // block lock and otp word
  localparam logic [7:0] OFF_SPARE = 8'h6C; // blank word
  // status bit positions
  localparam int SB_READY = 0; // power-up select delay elapsed
  localparam int SB_WEL = 1; // write enable latch
  localparam int SB_BUSY = 2; // parameter read in dummy or data phase
  localparam int SB_RVALID = 3; // result byte waiting
  localparam int SB_REJ = 4; // sticky: command refused
  localparam int SB_ARMED = 5; // reset enable seen
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0; // plain success
  localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address
  // command opcodes
  localparam logic [7:0] OP_PRM_RD = 8'h5A; // parameter-table read
  localparam logic [7:0] OP_WREN = 8'h06; // set write enable latch
  localparam logic [7:0] OP_WRDI = 8'h04; // clear write enable latch
  localparam logic [7:0] OP_RST_EN = 8'h66; // reset enable
  localparam logic [7:0] OP_RST = 8'h99; // software reset
  localparam logic [1:0] PW_BAD = 2'h3; // pin width code with no meaning
  // command word carried by the command register
  typedef struct packed {
    logic [7:0] addr; // parameter byte address
    logic [1:0] data_w; // data pin width code
    logic [1:0] addr_w; // address pin width code
    logic [1:0] cmd_w; // opcode pin width code
    logic [7:0] opcode; // command opcode
  } fvp_cmd_t;
  localparam int CMD_W = 22; // bits of fvp_cmd_t
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_DUMMY = 2'h1, ST_DATA = 2'h3} fvp_state_t;
  // timing
  localparam int CLK_PERIOD_NS = 10; // sys_clk period
  localparam int PUSD_NS = 1000; // power_up_select_delay, ns
  localparam int PUSD_CYC = (PUSD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // rounded up
  localparam int DUMMY_CYC = 8; // wait states after address
  localparam logic [3:0] DUMMY_LAST = 4'(DUMMY_CYC - 1); // last dummy count
  // parameter fields
  localparam logic [15:0] VCC_MAX = 16'h3600; // supply maximum field
  localparam logic [15:0] VCC_MIN = 16'h2650; // supply minimum field
  localparam logic [3:0] FEAT_PINS = 4'hE; // no reset pin, hold, dpd, sw reset
  localparam logic [3:0] FEAT_SUSP = 4'hF; // suspends, unused, wrap read
  localparam logic [7:0] WRAP_OP = 8'h77; // wrap-around read opcode
  localparam logic [7:0] WRAP_LEN = 8'h64; // 8, 16, 32 and 64 byte wraps
  localparam logic [3:0] LOCK_FLAGS = 4'hC; // read lock 0, perm lock 0, unused 11
  localparam logic [1:0] LOCK_MODE = 2'h3; // default unprotected, otp present
  localparam logic [7:0] LOCK_OP = 8'hFF; // block lock opcode
  localparam logic [1:0] LOCK_KIND = 2'h2; // nonvolatile, individual lock absent
  localparam logic [15:0] BLANK16 = 16'hFFFF; // unused half word
  localparam logic [31:0] BLANK32 = 32'hFFFF_FFFF; // unused word
  localparam logic [31:0] W_SUPPLY = {VCC_MIN, VCC_MAX};
  localparam logic [31:0] W_FEAT = {WRAP_LEN, WRAP_OP, FEAT_SUSP, OP_RST, FEAT_PINS};
  localparam logic [31:0] W_LOCK = {BLANK16, LOCK_FLAGS, LOCK_MODE, LOCK_OP, LOCK_KIND};

  // parameter word at an aligned byte address
  function automatic logic [31:0] fvp_prm_word(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    case (w)
      OFF_SUPPLY: fvp_prm_word = W_SUPPLY;
      OFF_FEAT: fvp_prm_word = W_FEAT;
      OFF_LOCK: fvp_prm_word = W_LOCK;
      default: fvp_prm_word = BLANK32;
    endcase
  endfunction : fvp_prm_word
endpackage : fvp_pkg

// ### logic/fvp_por_timer.sv
// power-up select delay counter started by reset release
// assumes arst_n is the power-on reset, released synchronously by the system
`timescale 1ns/1ns
module fvp_por_timer #(
  parameter int unsigned CYCLES = fvp_pkg::PUSD_CYC // delay length in cycles, 1..65535
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic arst_n, // power-on reset, active low
  output logic ready_q // delay elapsed, commands may run
);
  import fvp_pkg::*;
  localparam logic [15:0] LAST = 16'(CYCLES - 1); // final count value
  localparam logic [15:0] ONE = 16'h0001; // count step

  logic [15:0] cnt_q; // cycles since release

  // count up once, then hold
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (!ready_q) begin
      cnt_q <= cnt_q + ONE;
    end
  end

  // ready rises after the full delay
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_q <= 1'h0;
    end else if (cnt_q == LAST) begin
      ready_q <= 1'h1;
    end
  end

  ready_rise_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(ready_q) |-> $past(cnt_q) == LAST) else $error("ready rose before the delay ran out");
  ready_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ready_q |=> ready_q) else $error("ready dropped without reset");
endmodule : fvp_por_timer

// ### logic/fvp_rom.sv
// vendor parameter region, command gate and power-on state behind AXI4-Lite
// assumes the bus master runs on sys_clk; no synchronisers on bus inputs
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
// Functional notes
// - offsets 60h,61h read 00h,36h
// - offsets 62h,63h read 50h,26h
// - no reset pin; hold, dpd, reset supported
// - reset opcode 99h after 66h enable
// - suspend, wrap flags set; 66h reads 77h
// - offset 67h reads 64h wrap lengths
// - lock word reads CFFEh, upper ones
// - unused bytes including 6Ch-6Fh read FFh
// - parameter read only with uniform pin widths
// - dummy cycles follow address before data
// - power-up leaves write enable latch clear
// - read accepted after select delay elapses
module fvp_rom #(
  parameter int unsigned PUSD_CYCLES = fvp_pkg::PUSD_CYC // power-up select delay in cycles
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic power_up_done, // select delay elapsed
  output logic write_enable_latch // write enable latch state
);
  import fvp_pkg::*;
  localparam int DUMMY_LAT = DUMMY_CYC + 1; // launch to data state

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q; // handshake flops
  logic [1:0] bresp_q, rresp_q; // answers
  logic [31:0] rdata_q; // read data flop
  logic aw_full_q, w_full_q; // write halves held
  logic [7:0] awaddr_q; // held write address
  logic [31:0] wdata_q; // held write data
  logic [3:0] wstrb_q; // held strobes
  logic ready_q; // delay elapsed
  logic wel_q, armed_q, rej_q, res_valid_q; // control state
  logic [7:0] result_q; // last parameter byte
  logic [7:0] prm_addr_q; // byte under read
  logic [3:0] dcnt_q; // dummy cycle count
  fvp_state_t state_q; // read sequencer
  logic aw_hs, w_hs, ar_hs, do_write; // bus events
  logic [7:0] waddr, raddr; // aligned addresses
  fvp_cmd_t cmd; // command view of held data
  logic cmd_go, prm_cmd, uniform, accept_rd, reject; // command decode
  logic rej_clr, res_rd; // software side effects
  logic [31:0] rd_word; // read mux
  logic rd_err, wr_err; // unmapped decode
  logic [31:0] prm_w; // word holding the byte under read

  // power-up select delay
  fvp_por_timer #(
    .CYCLES(PUSD_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ready_q(ready_q)
  );

  // bus event decode
  always_comb begin
    aw_hs = s_axi_awvalid & awready_q;
    w_hs = s_axi_wvalid & wready_q;
    ar_hs = s_axi_arvalid & arready_q;
    do_write = aw_full_q & w_full_q & ~bvalid_q;
    waddr = {awaddr_q[7:2], 2'h0};
    raddr = {s_axi_araddr[7:2], 2'h0};
    wr_err = !(waddr inside {OFF_STATUS, OFF_CMD, OFF_RESULT, OFF_SUPPLY, OFF_FEAT, OFF_LOCK, OFF_SPARE});
    rd_err = !(raddr inside {OFF_STATUS, OFF_CMD, OFF_RESULT, OFF_SUPPLY, OFF_FEAT, OFF_LOCK, OFF_SPARE});
  end

  // command decode and gating
  always_comb begin
    cmd = fvp_cmd_t'(wdata_q[CMD_W-1:0]);
    cmd_go = do_write & (waddr == OFF_CMD) & (&wstrb_q[2:0]);
    prm_cmd = cmd_go & ready_q & (cmd.opcode == OP_PRM_RD);
    uniform = (cmd.cmd_w == cmd.addr_w) & (cmd.addr_w == cmd.data_w) & (cmd.cmd_w != PW_BAD);
    accept_rd = prm_cmd & uniform & (state_q == ST_IDLE);
    reject = prm_cmd & ~accept_rd;
    rej_clr = do_write & (waddr == OFF_STATUS) & wstrb_q[0] & wdata_q[SB_REJ];
    res_rd = ar_hs & (raddr == OFF_RESULT);
  end

  // write address channel
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      awready_q <= 1'h0;
      aw_full_q <= 1'h0;
      awaddr_q <= '0;
    end else if (aw_hs) begin
      awready_q <= 1'h0;
      aw_full_q <= 1'h1;
      awaddr_q <= s_axi_awaddr;
    end else if (bvalid_q & s_axi_bready) begin
      awready_q <= 1'h1;
      aw_full_q <= 1'h0;
    end else if (!aw_full_q) begin
      awready_q <= 1'h1; // open after reset
    end
  end

  // write data channel
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wready_q <= 1'h0;
      w_full_q <= 1'h0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (w_hs) begin
      wready_q <= 1'h0;
      w_full_q <= 1'h1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (bvalid_q & s_axi_bready) begin
      wready_q <= 1'h1;
      w_full_q <= 1'h0;
    end else if (!w_full_q) begin
      wready_q <= 1'h1;
    end
  end

  // write response after both halves
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_q <= 1'h0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'h1;
      bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'h0;
    end
  end

  // read data mux
  always_comb begin
    rd_word = '0;
    case (raddr)
      OFF_STATUS: begin
        rd_word[SB_READY] = ready_q;
        rd_word[SB_WEL] = wel_q;
        rd_word[SB_BUSY] = (state_q != ST_IDLE);
        rd_word[SB_RVALID] = res_valid_q;
        rd_word[SB_REJ] = rej_q;
        rd_word[SB_ARMED] = armed_q;
      end
      OFF_RESULT: rd_word[7:0] = result_q;
      OFF_SUPPLY, OFF_FEAT, OFF_LOCK, OFF_SPARE: rd_word = fvp_prm_word(raddr);
      default: rd_word = '0;
    endcase
  end

  // read channel, one cycle answer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      arready_q <= 1'h0;
      rvalid_q <= 1'h0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'h0;
      rvalid_q <= 1'h1;
      rdata_q <= rd_word;
      rresp_q <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_q <= 1'h0;
      arready_q <= 1'h1;
    end else if (!rvalid_q) begin
      arready_q <= 1'h1;
    end
  end

  // write enable latch, clear from reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wel_q <= 1'h0;
    end else if (cmd_go & ready_q) begin
      if (cmd.opcode == OP_WREN) begin
        wel_q <= 1'h1;
      end else if (cmd.opcode == OP_WRDI) begin
        wel_q <= 1'h0;
      end else if ((cmd.opcode == OP_RST) & armed_q) begin
        wel_q <= 1'h0;
      end
    end
  end

  // reset enable must directly precede reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_q <= 1'h0;
    end else if (cmd_go & ready_q) begin
      armed_q <= (cmd.opcode == OP_RST_EN);
    end
  end

  // refused flag, set wins over clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rej_q <= 1'h0;
    end else if (reject) begin
      rej_q <= 1'h1;
    end else if (rej_clr) begin
      rej_q <= 1'h0;
    end
  end

  // parameter read: dummy cycles then data
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      dcnt_q <= '0;
      prm_addr_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept_rd) begin
            state_q <= ST_DUMMY;
            dcnt_q <= '0;
            prm_addr_q <= cmd.addr;
          end
        end
        ST_DUMMY: begin
          if (dcnt_q == DUMMY_LAST) begin
            state_q <= ST_DATA;
          end else begin
            dcnt_q <= dcnt_q + 4'h1;
          end
        end
        ST_DATA: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // result byte and its valid flag; set wins over read-clear
  always_comb prm_w = fvp_prm_word(prm_addr_q);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= '0;
      res_valid_q <= 1'h0;
    end else if (state_q == ST_DATA) begin
      result_q <= prm_w[{prm_addr_q[1:0], 3'h0} +: 8];
      res_valid_q <= 1'h1;
    end else if (res_rd) begin
      res_valid_q <= 1'h0;
    end
  end

  // outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign power_up_done = ready_q;
  assign write_enable_latch = wel_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence rd_at(logic [7:0] a);
    ar_hs && raddr == a;
  endsequence
  sequence launch_rd;
    accept_rd ##1 (state_q == ST_DUMMY);
  endsequence
  supply_word_a: assert property (rd_at(OFF_SUPPLY) |=> s_axi_rdata == 32'h2650_3600)
    else $error("supply word wrong");
  feat_word_a: assert property (rd_at(OFF_FEAT) |=> s_axi_rdata == 32'h6477_F99E)
    else $error("feature word wrong");
  lock_word_a: assert property (rd_at(OFF_LOCK) |=> s_axi_rdata == 32'hFFFF_CFFE)
    else $error("lock word wrong");
  blank_word_a: assert property (rd_at(OFF_SPARE) |=> s_axi_rdata == 32'hFFFF_FFFF)
    else $error("blank word not all ones");
  mixed_refused_a: assert property (prm_cmd && !uniform && state_q == ST_IDLE |=> rej_q && state_q == ST_IDLE)
    else $error("mixed width read not refused");
  dummy_wait_a: assert property (launch_rd |-> ##(DUMMY_LAT - 1) state_q == ST_DATA)
    else $error("dummy phase length wrong");
  early_ignore_a: assert property (cmd_go && !ready_q |=> $stable(wel_q) && state_q == ST_IDLE)
    else $error("command ran before select delay");
  wel_clear_a: assert property (!ready_q |-> !wel_q)
    else $error("write enable latch set at power-up");
  soft_reset_a: assert property (armed_q && cmd_go && cmd.opcode == OP_RST |=> !wel_q)
    else $error("reset did not clear latch");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) // bus answer holds
    else $error("write response dropped early");
endmodule : fvp_rom

// ### tb/fvp_host_model.sv
// register bus host model for the vendor parameter block
// assumes an AXI4-Lite slave on sys_clk; only the bench timeout ends a wait
`timescale 1ns/1ns
module fvp_host_model (
  input wire logic sys_clk, // bus clock
  output logic [7:0] s_axi_awaddr, // write address
  output logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // byte strobes
  output logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write answer valid
  output logic s_axi_bready, // write answer ready
  output logic [7:0] s_axi_araddr, // read address
  output logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // read data valid
  output logic s_axi_rready // read data ready
);
  // idle bus from time zero, so no command lands before the bench asks
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // write: both channels offered at once, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a; // released lines do not keep the old value
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bready && s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
  endtask : wr

  // read: address held until taken, data taken at the answer edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rready && s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : fvp_host_model

// ### tb/fvp_rom_bench.sv
// self-checking bench for the vendor parameter block
// assumes fvp_pkg is compiled first; the host model drives the register bus
`timescale 1ns/1ns
module fvp_rom_bench;
  import fvp_pkg::*;
  typedef struct packed {
    logic [31:0] d; // expected data
    logic [31:0] m; // bits that matter
    logic [1:0] r; // expected answer code
  } fvp_exp_t;
  localparam int unsigned PUSD = 40; // shortened select delay
  // parameter bytes 60h..6Fh as the table gives them
  localparam logic [7:0] PRM [16] = '{8'h00, 8'h36, 8'h50, 8'h26, 8'h9E, 8'hF9, 8'h77, 8'h64,
    8'hFE, 8'hCF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  // mixed or invalid widths: opcode, address, data
  localparam logic [5:0] BAD [5] = '{6'h01, 6'h06, 6'h24, 6'h18, 6'h3F};
  logic sys_clk, arst_n, power_up_done, write_enable_latch;
  logic [7:0] s_axi_awaddr, s_axi_araddr, a;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int fails, check_count, cyc, n, w;
  integer seed; // random seed
  fvp_exp_t expq [$];
  fvp_exp_t e;

  fvp_rom #(.PUSD_CYCLES(PUSD)) dut_u (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .power_up_done, .write_enable_latch);
  fvp_host_model host_u (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  task automatic end_of_test();
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  // compare one bus answer against its note
  task automatic cmp_rd(input logic [31:0] d, input logic [1:0] r, input fvp_exp_t x);
    check_count++;
    if (((d & x.m) !== (x.d & x.m)) || (r !== x.r)) begin
      fails++;
      $display("mismatch at %0t: got %h/%h want %h/%h", $time, d, r, x.d, x.r);
    end
  endtask : cmp_rd

  // compare one status pin
  task automatic cmp_bit(input logic g, input logic x);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("mismatch at %0t: pin %b want %b", $time, g, x);
    end
  endtask : cmp_bit

  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
    expq.push_back('{32'h0000_0000, 32'h0000_0000, RESP_OKAY});
    host_u.wr(ad, d, s);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    expq.push_back('{d, m, r});
    host_u.rd(ad, rdv);
  endtask : rd

  // command word carries no mode bits, so the address runs straight into the dummy cycles
  task automatic cmd(input logic [7:0] op, input logic [1:0] cw, input logic [1:0] aw,
    input logic [1:0] dw, input logic [7:0] ad);
    fvp_cmd_t c;
    c = '{addr: ad, data_w: dw, addr_w: aw, cmd_w: cw, opcode: op};
    wr(OFF_CMD, {10'h000, c}, 4'hF);
  endtask : cmd

  // parameter read, poll for the byte, then check it
  task automatic prm(input logic [7:0] ad, input logic [1:0] pw);
    int k;
    cmd(OP_PRM_RD, pw, pw, pw, ad);
    rd(OFF_STATUS, 32'h0000_0004, 32'h0000_000C, RESP_OKAY);
    rdv = 32'h0000_0000;
    k = 0;
    while (rdv[SB_RVALID] !== 1'b1 && k < 40) begin
      rd(OFF_STATUS, 32'h0000_0000, 32'h0000_0000, RESP_OKAY);
      k++;
    end
    rd(OFF_RESULT, {24'h00_0000, (ad[7:4] == 4'h6) ? PRM[ad[3:0]] : 8'hFF}, 32'h0000_00FF, RESP_OKAY);
  endtask : prm

  // answer watcher: oldest note against each finished response
  always @(posedge sys_clk) begin
    if (arst_n === 1'b1 && ((s_axi_bvalid & s_axi_bready) === 1'b1 || (s_axi_rvalid & s_axi_rready) === 1'b1)) begin
      if (expq.size() == 0) begin
        fails++;
        $display("mismatch at %0t: answer with no note", $time);
      end else begin
        e = expq.pop_front();
        if (s_axi_rvalid === 1'b1) cmp_rd(s_axi_rdata, s_axi_rresp, e);
        else cmp_rd(32'h0000_0000, s_axi_bresp, e);
      end
    end
  end

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test();
    end
  end

  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    fails = 0;
    check_count = 0;
    cyc = 0;
    seed = 32'h6097_6d3f;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    cmd(OP_WREN, 2'h0, 2'h0, 2'h0, 8'h00); // too early on purpose, before the select delay
    rd(OFF_STATUS, 32'h0000_0000, 32'h0000_0023, RESP_OKAY);
    cmp_bit(power_up_done, 1'b0);
    for (n = 0; n < 200 && power_up_done !== 1'b1; n++) @(posedge sys_clk);
    cmp_bit(power_up_done, 1'b1);
    rd(OFF_STATUS, 32'h0000_0001, 32'h0000_002F, RESP_OKAY);
    rd(OFF_SUPPLY, 32'h2650_3600, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_FEAT, 32'h6477_F99E, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_LOCK, 32'hFFFF_CFFE, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_SPARE, 32'hFFFF_FFFF, 32'hFFFF_FFFF, RESP_OKAY);
    wr(OFF_SUPPLY, 32'h0000_0000, 4'hF);
    rd(OFF_SUPPLY, 32'h2650_3600, 32'hFFFF_FFFF, RESP_OKAY);
    rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
    for (w = 0; w < 3; w++)
      for (n = 0; n < 16; n++) prm(8'h60 + 8'(n), 2'(w));
    repeat (6) begin
      a = 8'($random(seed));
      if (a[7:4] == 4'h6) a[7] = 1'b1;
      prm(a, 2'(unsigned'($random(seed)) % 3));
    end
    foreach (BAD[i]) begin
      cmd(OP_PRM_RD, BAD[i][5:4], BAD[i][3:2], BAD[i][1:0], 8'h60);
      rd(OFF_STATUS, 32'h0000_0010, 32'h0000_0014, RESP_OKAY);
      wr(OFF_STATUS, 32'h0000_0010, 4'h1);
      rd(OFF_STATUS, 32'h0000_0000, 32'h0000_0010, RESP_OKAY);
    end
    cmd(OP_WREN, 2'h0, 2'h0, 2'h0, 8'h00);
    cmd(OP_RST_EN, 2'h0, 2'h0, 2'h0, 8'h00); // enable before reset
    rd(OFF_STATUS, 32'h0000_0022, 32'h0000_0022, RESP_OKAY);
    cmd(OP_RST, 2'h0, 2'h0, 2'h0, 8'h00);
    rd(OFF_STATUS, 32'h0000_0000, 32'h0000_0022, RESP_OKAY);
    cmd(OP_WREN, 2'h0, 2'h0, 2'h0, 8'h00);
    cmd(OP_RST_EN, 2'h0, 2'h0, 2'h0, 8'h00);
    cmd(OP_WREN, 2'h0, 2'h0, 2'h0, 8'h00);
    cmd(OP_RST, 2'h0, 2'h0, 2'h0, 8'h00);
    rd(OFF_STATUS, 32'h0000_0002, 32'h0000_0022, RESP_OKAY);
    cmp_bit(write_enable_latch, 1'b1);
    // second power-on reset in mid-run
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    cmp_bit(write_enable_latch, 1'b0);
    cmp_bit(power_up_done, 1'b0);
    rd(OFF_STATUS, 32'h0000_0000, 32'h0000_0003, RESP_OKAY);
    end_of_test();
  end
endmodule : fvp_rom_bench
